// ===== hw/sar_adc_pkg.sv
// Shared constants for the converter control ends and the serial link.
// Assumes a 250 MHz ref_clk on both ends.
package sar_adc_pkg;
    localparam int RESULT_BITS      = 10;
    localparam int CNT_W            = 10;
    localparam int BIT_CNT_W        = 4;
    localparam int REF_PERIOD_PS    = 4000;
    // Times as printed, in ns
    localparam int CONV_TIME_NS     = 2300;
    localparam int WAKE_TIME_NS     = 1500;
    // Least times round up to whole cycles
    localparam int CONV_CYC =
        (CONV_TIME_NS * 1000 + REF_PERIOD_PS - 1) / REF_PERIOD_PS;
    localparam int WAKE_CYC =
        (WAKE_TIME_NS * 1000 + REF_PERIOD_PS - 1) / REF_PERIOD_PS;
    // Host side: half period of the serial clock in ref_clk cycles
    localparam int SCLK_HALF_CYC    = 10;
    localparam int CS_PULSE_CYC     = 8;
    // Covers result handover into the serial clock domain
    localparam int READ_MARGIN_CYC  = 8 * SCLK_HALF_CYC * 2;
    localparam int READ_WAIT_CYC    = CONV_CYC + READ_MARGIN_CYC;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hA;
endpackage

// ===== hw/adc_link_if.sv
// Three-wire serial link between converter and host.
// The bench resolves the data wire from dOut and dOutOe.
`timescale 1ns/1ns
interface adc_link_if;
    logic sclk;
    logic convertStartN;
    logic dOut;
    logic dOutOe;

    modport device (
        input  sclk,
        input  convertStartN,
        output dOut,
        output dOutOe
    );

    modport host (
        output sclk,
        output convertStartN,
        input  dOut,
        input  dOutOe
    );
endinterface

// ===== hw/adc_device_end.sv
// Converter end: conversion timing and power control on ref_clk,
// result shifter on the link serial clock.
// Assumes analogCode is the front end's digitised level on ref_clk.
`timescale 1ns/1ns

// Operation
// - Start-pin fall holds sample, starts conversion
// - Conversion ends after 2.3us, loads, samples pin
// - Pin high at end keeps device powered
// - Pin low at end powers device down
// - Rising edge wakes device, 1.5us wake-up
// - Early fall waits out wake-up, then converts
// - Rising edge enables serial port for reads
// - Read before conversion end gives previous result
// - New result waits until running read finishes; code can still load it on the sclk rise that shifts the first bit
// - Host waits 2.3us after fall for fresh result
// - Serial port works while powered down
// - Host finishes read before next rising edge
// - Rising edge clears serial bit counter
// - Clocks ignored after ten bits; tenth ends transfer
// - First bit on first rising clock after enable; code shifts it on the fourth sclk rise at the soonest
// - Output released on tenth falling clock edge
// - No data out before a rising edge
// - Works with continuous or gated serial clock
// - Host samples on falling serial clock edge
// - Eight-bit hosts use two transfers per result
// - Starts powered down; pin low at power-up
// - Result is straight binary, step Vref/1024
module adc_device_end
    import sar_adc_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    adc_link_if.device                  link,
    input  wire logic [RESULT_BITS-1:0] analogCode,
    output logic                        powered,
    output logic                        tracking,
    output logic [RESULT_BITS-1:0]      lastResult
);

    typedef enum logic [1:0] {
        PWR_DOWN,
        WAKING,
        READY,
        CONVERTING
    } dev_state_e;

    function automatic logic pickBit(
        input logic [RESULT_BITS-1:0] word,
        input logic [BIT_CNT_W-1:0]   idx
    );
        logic [BIT_CNT_W-1:0] pos;
        pos = BIT_CNT_W'(RESULT_BITS - 1) - idx;
        return word[pos];
    endfunction

    // ---------------- ref_clk domain ----------------
    dev_state_e                 state;
    dev_state_e                 next_state;
    logic                       csMeta;
    logic                       csSync;
    logic                       csPrev;
    logic [CNT_W-1:0]           timer;
    logic                       fallSeen;
    logic [RESULT_BITS-1:0]     heldCode;
    logic [RESULT_BITS-1:0]     xferWord;
    logic                       loadPending;
    logic                       reqTgl;
    logic                       ackMeta;
    logic                       ackSync;
    logic                       ackTgl;
    logic                       riseTgl;
    logic                       riseAckMeta;
    logic                       riseAckSync;
    logic                       sPrev;

    wire csFall    = csPrev & ~csSync;
    wire csRise    = ~csPrev & csSync;
    wire wakeDone  = (state == WAKING) && (timer == CNT_W'(WAKE_CYC - 1));
    wire convDone  = (state == CONVERTING)
                     && (timer == CNT_W'(CONV_CYC - 1));
    wire startConv = (next_state == CONVERTING) && (state != CONVERTING);
    wire sendOk    = loadPending && (reqTgl == ackSync);

    // Pin reset value low keeps the first edge a rise, never a fall
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            csMeta <= 1'b0;
            csSync <= 1'b0;
            csPrev <= 1'b0;
        end else begin
            csMeta <= link.convertStartN;
            csSync <= csMeta;
            csPrev <= csSync;
        end
    end

    // Enable request kept as a toggle, so a stopped sclk loses no rise
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            riseTgl     <= 1'b0;
            riseAckMeta <= 1'b0;
            riseAckSync <= 1'b0;
        end else begin
            riseAckMeta <= sPrev;
            riseAckSync <= riseAckMeta;
            if (csRise && (riseTgl == riseAckSync)) begin
                riseTgl <= ~riseTgl;
            end
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            PWR_DOWN:   if (csRise) next_state = WAKING;
            WAKING: begin
                if (wakeDone) begin
                    if (fallSeen || csFall) begin
                        next_state = CONVERTING;
                    end else begin
                        next_state = READY;
                    end
                end
            end
            READY:      if (csFall) next_state = CONVERTING;
            CONVERTING: begin
                if (convDone) begin
                    // Pin level at the end picks the power mode
                    if (csSync) begin
                        next_state = READY;
                    end else begin
                        next_state = PWR_DOWN;
                    end
                end
            end
            default:    next_state = PWR_DOWN;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= PWR_DOWN;
            timer <= '0;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                timer <= '0;
            end else begin
                timer <= timer + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fallSeen <= 1'b0;
            heldCode <= '0;
        end else begin
            fallSeen <= (state == WAKING) && (fallSeen || csFall);
            if (startConv) begin
                heldCode <= analogCode;
            end
        end
    end

    // Result handover: toggle request, word held until acknowledged
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lastResult  <= '0;
            xferWord    <= '0;
            loadPending <= 1'b0;
            reqTgl      <= 1'b0;
            ackMeta     <= 1'b0;
            ackSync     <= 1'b0;
        end else begin
            ackMeta <= ackTgl;
            ackSync <= ackMeta;
            if (convDone) begin
                lastResult <= heldCode;
            end
            if (sendOk) begin
                xferWord <= lastResult;
                reqTgl   <= ~reqTgl;
            end
            // A conversion ending in the send cycle stays pending
            loadPending <= convDone || (loadPending && !sendOk);
        end
    end

    assign powered  = (state != PWR_DOWN);
    assign tracking = (state != CONVERTING);

    // ---------------- serial clock domain ----------------
    logic                       lrMeta;
    logic                       linkRstN;
    logic                       sMeta;
    logic                       sSync;
    logic                       reqMeta;
    logic                       reqSync;
    logic [RESULT_BITS-1:0]     outWord;
    logic [BIT_CNT_W-1:0]       bitCnt;
    logic                       active;
    logic                       dOutBit;
    logic                       endFlag;

    wire enableRise = sSync ^ sPrev;
    wire shifting   = active && (bitCnt != '0);
    wire moreBits   = active && (bitCnt < LAST_BIT);
    wire loadNew    = (reqSync != ackTgl) && !shifting;

    // Held in reset until the host first runs sclk
    always_ff @(posedge link.sclk or negedge rst_n) begin
        if (!rst_n) begin
            lrMeta   <= 1'b0;
            linkRstN <= 1'b0;
        end else begin
            lrMeta   <= 1'b1;
            linkRstN <= lrMeta;
        end
    end

    always_ff @(posedge link.sclk or negedge linkRstN) begin
        if (!linkRstN) begin
            sMeta   <= 1'b0;
            sSync   <= 1'b0;
            sPrev   <= 1'b0;
            reqMeta <= 1'b0;
            reqSync <= 1'b0;
        end else begin
            sMeta   <= riseTgl;
            sSync   <= sMeta;
            sPrev   <= sSync;
            reqMeta <= reqTgl;
            reqSync <= reqMeta;
        end
    end

    // Shifter reload blocked from the second bit on, so bits two to ten of a read come from one word
    always_ff @(posedge link.sclk or negedge linkRstN) begin
        if (!linkRstN) begin
            outWord <= '0;
            ackTgl  <= 1'b0;
        end else if (loadNew) begin
            outWord <= xferWord;
            ackTgl  <= reqSync;
        end
    end

    always_ff @(posedge link.sclk or negedge linkRstN) begin
        if (!linkRstN) begin
            bitCnt  <= '0;
            active  <= 1'b0;
            dOutBit <= 1'b0;
        end else if (enableRise) begin
            bitCnt <= '0;
            active <= 1'b1;
        end else if (endFlag) begin
            active <= 1'b0;
        end else if (moreBits) begin
            dOutBit <= pickBit(outWord, bitCnt);
            bitCnt  <= bitCnt + BIT_CNT_W'(1);
        end
    end

    // Falling edge of the tenth clock ends the transfer
    always_ff @(negedge link.sclk or negedge linkRstN) begin
        if (!linkRstN) begin
            endFlag <= 1'b0;
        end else begin
            endFlag <= active && (bitCnt == LAST_BIT) && !endFlag;
        end
    end

    // Port idles undriven until a rising enable edge
    assign link.dOutOe = shifting && !endFlag;
    assign link.dOut   = dOutBit;

endmodule

// ===== hw/adc_host_end.sv
// Host end: drives the start pin and a divided serial clock,
// collects a 10-bit result sampled on falling serial clock edges.
// Assumes startConv and readReq are ref_clk pulses from user logic.
`timescale 1ns/1ns
module adc_host_end
    import sar_adc_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    adc_link_if.host                    link,
    input  wire logic                   startConv,
    input  wire logic                   autoPowerDown,
    input  wire logic                   readReq,
    output logic                        busy,
    output logic [RESULT_BITS-1:0]      result,
    output logic                        resultValid
);

    typedef enum logic [2:0] {
        H_IDLE,
        H_WAKE,
        H_LOW,
        H_READ_WAIT,
        H_READ
    } host_state_e;

    host_state_e                state;
    logic [CNT_W-1:0]           divCnt;
    logic                       sclkReg;
    logic [CNT_W-1:0]           phaseCnt;
    logic [CNT_W-1:0]           convTimer;
    logic                       csN;
    logic                       modeAuto;
    logic                       dMeta;
    logic                       dSync;
    logic                       oeMeta;
    logic                       oeSync;
    logic [BIT_CNT_W-1:0]       bitCnt;

    wire divWrap   = (divCnt == CNT_W'(SCLK_HALF_CYC - 1));
    wire sclkFall  = sclkReg && divWrap;
    wire pulseDone = (phaseCnt == CNT_W'(CS_PULSE_CYC - 1));
    wire convReady = (convTimer == CNT_W'(READ_WAIT_CYC));
    wire takeBit   = (state == H_READ) && sclkFall && oeSync;

    // Gated serial clock, runs only while reading; stops after a fall
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            divCnt  <= '0;
            sclkReg <= 1'b0;
        end else if (state != H_READ) begin
            divCnt  <= '0;
            sclkReg <= 1'b0;
        end else begin
            divCnt <= divWrap ? '0 : divCnt + CNT_W'(1);
            if (divWrap) begin
                sclkReg <= ~sclkReg;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dMeta  <= 1'b0;
            dSync  <= 1'b0;
            oeMeta <= 1'b0;
            oeSync <= 1'b0;
        end else begin
            dMeta  <= link.dOut;
            dSync  <= dMeta;
            oeMeta <= link.dOutOe;
            oeSync <= oeMeta;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state       <= H_IDLE;
            csN         <= 1'b0;
            modeAuto    <= 1'b0;
            phaseCnt    <= '0;
            convTimer   <= CNT_W'(READ_WAIT_CYC);
            bitCnt      <= '0;
            result      <= '0;
            resultValid <= 1'b0;
        end else begin
            resultValid <= 1'b0;
            phaseCnt    <= phaseCnt + CNT_W'(1);
            if (!convReady) begin
                convTimer <= convTimer + CNT_W'(1);
            end
            case (state)
                H_IDLE: begin
                    phaseCnt <= '0;
                    bitCnt   <= '0;
                    if (startConv) begin
                        csN      <= 1'b1;
                        modeAuto <= autoPowerDown;
                        state    <= H_WAKE;
                    end else if (readReq) begin
                        state <= H_READ_WAIT;
                    end
                end
                H_WAKE: begin
                    csN <= 1'b1;
                    if (pulseDone) begin
                        csN      <= 1'b0;
                        phaseCnt <= '0;
                        state    <= H_LOW;
                    end
                end
                H_LOW: begin
                    csN       <= 1'b0;
                    convTimer <= '0;
                    if (pulseDone) begin
                        // Mode 1 raises early, mode 2 stays low
                        csN   <= modeAuto ? 1'b0 : 1'b1;
                        state <= H_IDLE;
                    end
                end
                H_READ_WAIT: begin
                    if (convReady) begin
                        csN   <= 1'b1;
                        state <= H_READ;
                    end
                end
                H_READ: begin
                    if (takeBit) begin
                        result <= {result[RESULT_BITS-2:0], dSync};
                        bitCnt <= bitCnt + BIT_CNT_W'(1);
                        if (bitCnt == LAST_BIT - BIT_CNT_W'(1)) begin
                            resultValid <= 1'b1;
                            state       <= H_IDLE;
                        end
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    assign busy               = (state != H_IDLE);
    assign link.sclk          = sclkReg;
    assign link.convertStartN = csN;

endmodule

// ===== tb/sar_adc_monitor.sv
// Link checker for the start pin, serial clock and data output.
// Assumes sclk is made from ref_clk by the host divider.
`timescale 1ns/1ns
module sar_adc_monitor (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic convertStartN,
    input wire logic dOut,
    input wire logic dOutOe
);
    logic [3:0] bitCnt;

    // Counts rises seen with the output already on
    always_ff @(posedge sclk) begin
        if (!dOutOe) begin
            bitCnt <= 4'h0;
        end else begin
            bitCnt <= bitCnt + 4'h1;
        end
    end

    property p_oeNeedsRise;
        @(posedge sclk) disable iff (!rst_n)
        $rose(dOutOe) |-> convertStartN;
    endproperty
    a_oeNeedsRise: assert property (p_oeNeedsRise)
        else $error("data driven while start pin low");

    property p_bitsHeld;
        @(negedge sclk) disable iff (!rst_n)
        dOutOe && (bitCnt < 4'h9) |=> dOutOe;
    endproperty
    a_bitsHeld: assert property (p_bitsHeld)
        else $error("output released before ten bits");

    property p_releaseAfterTen;
        @(negedge sclk) disable iff (!rst_n)
        dOutOe && (bitCnt == 4'h9) |=> !dOutOe;
    endproperty
    a_releaseAfterTen: assert property (p_releaseAfterTen)
        else $error("output still driven after tenth bit");

    property p_shiftOnRise;
        @(posedge ref_clk) disable iff (!rst_n)
        dOutOe && $past(dOutOe) && $changed(dOut) |-> $rose(sclk);
    endproperty
    a_shiftOnRise: assert property (p_shiftOnRise)
        else $error("data changed away from a rising sclk");

    property p_releaseOnFall;
        @(posedge ref_clk) disable iff (!rst_n)
        $fell(dOutOe) |-> $fell(sclk);
    endproperty
    a_releaseOnFall: assert property (p_releaseOnFall)
        else $error("output released away from a falling sclk");

    property p_readBeforeRise;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(convertStartN) |-> !dOutOe;
    endproperty
    a_readBeforeRise: assert property (p_readBeforeRise)
        else $error("start pin rose during a read");

    property p_startPulse;
        @(posedge ref_clk) disable iff (!rst_n)
        $fell(convertStartN) |-> !convertStartN [*8];
    endproperty
    a_startPulse: assert property (p_startPulse)
        else $error("start pin low pulse too short");

    property p_wakeHigh;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(convertStartN) |-> convertStartN [*8];
    endproperty
    a_wakeHigh: assert property (p_wakeHigh)
        else $error("start pin high pulse too short");

    // Gated divider stops only after a fall, so high phases stay whole
    property p_sclkHalf;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(sclk) |-> sclk [*8] ##1 sclk [*2] ##1 !sclk;
    endproperty
    a_sclkHalf: assert property (p_sclkHalf)
        else $error("sclk high phase of wrong length");
endmodule

// ===== tb/sar_adc_convert_power_serial_readout_tb_top.sv
// Bench: host end and converter end joined by the serial link.
// Assumes both ends share ref_clk and the synchronous rst_n.
`timescale 1ns/1ns
module sar_adc_convert_power_serial_readout_tb_top
    import sar_adc_pkg::*;
;
    typedef struct packed {
        logic                   mode;
        logic [RESULT_BITS-1:0] code;
    } row_s;
    localparam row_s ROWS [5] = '{'{1'h0, 10'h3FF}, '{1'h1, 10'h000},
        '{1'h0, 10'h2AA}, '{1'h1, 10'h155}, '{1'h0, 10'h200}};

    logic                   ref_clk = 1'b0;
    logic                   rst_n;
    logic                   startConv;
    logic                   autoPowerDown;
    logic                   readReq;
    logic [RESULT_BITS-1:0] analogCode;
    logic                   busy;
    logic                   resultValid;
    logic                   powered;
    logic                   tracking;
    logic [RESULT_BITS-1:0] result;
    logic [RESULT_BITS-1:0] lastResult;
    logic [3:0]             mon;
    int                     errCount;
    int                     samplesChecked;
    int                     n;

    always #2 ref_clk = ~ref_clk;

    adc_link_if link ();

    adc_host_end adc_host_end_inst (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .link          (link.host),
        .startConv     (startConv),
        .autoPowerDown (autoPowerDown),
        .readReq       (readReq),
        .busy          (busy),
        .result        (result),
        .resultValid   (resultValid)
    );

    adc_device_end adc_device_end_inst (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .link       (link.device),
        .analogCode (analogCode),
        .powered    (powered),
        .tracking   (tracking),
        .lastResult (lastResult)
    );

    sar_adc_monitor sar_adc_monitor_inst (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .sclk          (link.sclk),
        .convertStartN (link.convertStartN),
        .dOut          (link.dOut),
        .dOutOe        (link.dOutOe)
    );

    assign mon = {busy, resultValid, tracking, link.convertStartN};

    task automatic endOfTest();
        if (errCount == 0 && samplesChecked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            errCount++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bounded wait for one watched flag to reach a level
    task automatic waitBit(input int i, input logic v, input int lim,
                           output int cnt);
        cnt = 0;
        while (mon[i] !== v && cnt < lim) begin
            @(posedge ref_clk);
            #1;
            cnt++;
        end
        if (cnt >= lim) begin
            errCount++;
            $display("FAIL t=%0t got=%h exp=%h", $time, mon[i], v);
        end
    endtask

    task automatic doConv(input logic m);
        @(posedge ref_clk);
        #1;
        autoPowerDown = m;
        startConv = 1'b1;
        @(posedge ref_clk);
        #1;
        startConv = 1'b0;
    endtask

    task automatic readOne(input logic [RESULT_BITS-1:0] exp);
        int c;
        waitBit(3, 1'b0, 100, c);
        @(posedge ref_clk);
        #1;
        readReq = 1'b1;
        @(posedge ref_clk);
        #1;
        readReq = 1'b0;
        waitBit(2, 1'b1, 2000, c);
        check(result, exp);
    endtask

    initial begin
        {rst_n, startConv, autoPowerDown, readReq} = 4'h0;
        analogCode = 10'h000;
        errCount = 0;
        samplesChecked = 0;
        repeat (15) @(posedge ref_clk);
        #1;
        check({busy, resultValid, link.convertStartN, powered, tracking},
              16'h0001);
        check(16'(result), 16'h0000);
        check(16'(lastResult), 16'h0000);
        @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        foreach (ROWS[i]) begin
            analogCode = ROWS[i].code;
            doConv(ROWS[i].mode);
            waitBit(3, 1'b0, 100, n);
            waitBit(1, 1'b0, 1000, n);
            waitBit(1, 1'b1, 1000, n);
            repeat (2) @(posedge ref_clk);
            #1;
            check(powered, !ROWS[i].mode);
            readOne(ROWS[i].code);
            check(lastResult, ROWS[i].code);
        end
        // Power down, then wake with a start pulse shorter than wake-up
        analogCode = 10'h0F0;
        doConv(1'b1);
        waitBit(1, 1'b0, 1000, n);
        waitBit(1, 1'b1, 1000, n);
        doConv(1'b0);
        waitBit(0, 1'b1, 20, n);
        waitBit(1, 1'b0, 1000, n);
        check(n >= WAKE_CYC && n <= WAKE_CYC + 8, 1'b1);
        // Input moves after the hold point and must not be seen
        analogCode = 10'h30F;
        waitBit(1, 1'b1, 1000, n);
        check(n >= CONV_CYC - 1 && n <= CONV_CYC + 1, 1'b1);
        check(powered, 1'b1);
        readOne(10'h0F0);
        endOfTest();
    end

    initial begin
        repeat (30000) @(posedge ref_clk);
        errCount++;
        endOfTest();
    end
endmodule
